// File: logic/gpt_cfg.svh
// register map, field positions, reset values and prescale ratios of the period timer
`ifndef GPT_CFG_SVH
`define GPT_CFG_SVH

`define GPT_ADR_W          8
`define GPT_OFF_CTRL       8'h00
`define GPT_OFF_COUNT      8'h04
`define GPT_OFF_PERIOD     8'h08
`define GPT_OFF_STATUS     8'h0C
`define GPT_OFF_MASK       8'h10
`define GPT_OFF_IRQCFG     8'h14

`define GPT_CTRL_RUN       15
`define GPT_CTRL_SIDL      13
`define GPT_CTRL_GATE      6
`define GPT_CTRL_PS_HI     5
`define GPT_CTRL_PS_LO     4
`define GPT_CTRL_SYNC      2
`define GPT_CTRL_SRC       1
`define GPT_CTRL_RST       7'h00

`define GPT_IRQ_W          2
`define GPT_IRQ_MATCH      0
`define GPT_IRQ_GATE       1
`define GPT_MASK_RST       2'h3

`define GPT_IRQCFG_EN      0
`define GPT_IRQCFG_PRIO_LO 1
`define GPT_PRIO_W         3
`define GPT_PRIO_RST       3'h0

`define GPT_DIV_W          9
`define GPT_DIV_1          9'h001
`define GPT_DIV_8          9'h008
`define GPT_DIV_64         9'h040
`define GPT_DIV_256        9'h100

`endif

// File: logic/gpt_pkg.sv
// types shared by the period timer modules
package gpt_pkg;

   typedef struct packed {
      logic       run;
      logic       stop_idle;
      logic       gate_en;
      logic [1:0] prescale;
      logic       ext_sync;
      logic       src_ext;
   } gpt_ctrl_t;

   typedef struct packed {
      logic [7:0]  adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
   } gpt_wb_req_t;

   typedef enum logic [1:0] {
      GPT_BUS_IDLE = 2'b01,
      GPT_BUS_ACK  = 2'b10
   } gpt_bus_state_t;

endpackage

// File: logic/gpt_edge_sync.sv
// two-stage synchroniser with edge detection and an optional unsynchronised path
`timescale 1ns/10ps
module gpt_edge_sync (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // signal
   input  wire logic sig_i,
   input  wire logic bypass_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta_r;
   logic sync_r;
   logic prev_r;
   wire  sel_w = bypass_i ? sig_i : sync_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= sig_i;
         sync_r <= meta_r;
         prev_r <= sel_w;
      end
   end

   // bypass saves two cycles of latency at the price of metastability margin
   assign level_o = sel_w;
   assign rise_o  = sel_w & ~prev_r;
   assign fall_o  = ~sel_w & prev_r;
endmodule

// File: logic/gpt_prescaler.sv
// input clock prescaler producing one tick per programmed number of input ticks
`timescale 1ns/10ps
module gpt_prescaler #(
   parameter int DIV_W = 9
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // control
   input  wire logic             clear_i,
   input  wire logic [DIV_W-1:0] ratio_i,
   // ticks
   input  wire logic             tick_i,
   output logic                  tick_o
);
   logic [DIV_W-1:0] cnt_r;
   wire              last_w = (cnt_r == (ratio_i - DIV_W'(1))) || (cnt_r >= ratio_i);

   if (DIV_W < 1) begin : g_chk
      $error("gpt_prescaler: DIV_W must be at least 1");
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         cnt_r <= '0;
      end else if (tick_i) begin
         cnt_r <= last_w ? '0 : cnt_r + DIV_W'(1);
      end
   end

   assign tick_o = tick_i & last_w;
endmodule

// File: logic/gpt_timer.sv
// gated, prescaled period timer with a classic wishbone register slave
//
// Summary of operation
// - A counter of CNT_W bits, sixteen by default, runs as a time base or interval counter.
// - It counts the internal clock, a synchronised external clock or a raw external clock.
// - It keeps counting in idle and sleep as its configuration allows.
// - A count equal to the period value sets the match interrupt flag.
// - In gated mode it counts only while the gate is high and flags the gate falling edge.
// - Setting the run bit in the control register starts the counting.
// - A two-bit prescale field set by software divides the input clock.
// - Separate control bits pick the clock source and gated accumulation.
// - A control bit picks synchronised or unsynchronised external clock counting.
// - Software loads the period register and the count is compared against it.
// - The interrupt reaches the cpu only when enabled and carries a 3-bit priority.
// - With run set the timer counts, with run clear it stops.
// - The gated accumulation bit is ignored while the external source is chosen.
// - Prescale 11 divides by 256, 10 by 64 and 01 by 8.
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "gpt_cfg.svh"
module gpt_timer #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // wishbone slave
   input  wire logic                   cyc_i,
   input  wire logic                   stb_i,
   input  wire logic                   we_i,
   input  wire logic [7:0]             adr_i,
   input  wire logic [3:0]             sel_i,
   input  wire logic [31:0]            dat_i,
   output logic      [31:0]            dat_o,
   output logic                        ack_o,
   // power state
   input  wire logic                   idle_i,
   input  wire logic                   sleep_i,
   // external clock and gate
   input  wire logic                   ext_clk_i,
   input  wire logic                   gate_i,
   // interrupt
   output logic                        irq_o,
   output logic      [`GPT_PRIO_W-1:0] irq_priority_o
);
   if (CNT_W < 2 || CNT_W > 32) begin : g_chk
      $error("gpt_timer: CNT_W must lie between 2 and 32");
   end

   function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [`GPT_DIV_W-1:0] ps_ratio(input logic [1:0] ps);
      logic [`GPT_DIV_W-1:0] r;
      r = `GPT_DIV_1;
      case (ps)
         2'b11:   r = `GPT_DIV_256;
         2'b10:   r = `GPT_DIV_64;
         2'b01:   r = `GPT_DIV_8;
         default: r = `GPT_DIV_1;
      endcase
      return r;
   endfunction

   // registers
   gpt_pkg::gpt_ctrl_t      ctrl_r;
   gpt_pkg::gpt_ctrl_t      ctrl_nxt;
   logic [CNT_W-1:0]        count_r;
   logic [CNT_W-1:0]        count_nxt;
   logic [CNT_W-1:0]        period_r;
   logic [`GPT_IRQ_W-1:0]   status_r;
   logic [`GPT_IRQ_W-1:0]   status_nxt;
   logic [`GPT_IRQ_W-1:0]   mask_r;
   logic                    irq_en_r;
   logic [`GPT_PRIO_W-1:0]  prio_r;
   gpt_pkg::gpt_bus_state_t bus_r;
   gpt_pkg::gpt_bus_state_t bus_nxt;
   gpt_pkg::gpt_wb_req_t    req;
   logic [31:0]             rd_data;

   // bus decode
   assign req = '{adr: adr_i, dat: dat_i, sel: sel_i, we: we_i};
   wire take_w    = cyc_i & stb_i & (bus_r == gpt_pkg::GPT_BUS_IDLE);
   wire wr_w      = take_w & req.we;
   wire rd_w      = take_w & ~req.we;
   wire hit_ctrl  = (req.adr == `GPT_OFF_CTRL);
   wire hit_count = (req.adr == `GPT_OFF_COUNT);
   wire hit_per   = (req.adr == `GPT_OFF_PERIOD);
   wire hit_stat  = (req.adr == `GPT_OFF_STATUS);
   wire hit_mask  = (req.adr == `GPT_OFF_MASK);
   wire hit_icfg  = (req.adr == `GPT_OFF_IRQCFG);
   wire ctrl_wr   = wr_w & hit_ctrl;
   wire count_wr  = wr_w & hit_count;

   wire [31:0] ctrl_word = {16'h0000, ctrl_r.run, 1'b0, ctrl_r.stop_idle, 6'h00,
                            ctrl_r.gate_en, ctrl_r.prescale, 1'b0, ctrl_r.ext_sync,
                            ctrl_r.src_ext, 1'b0};
   wire [31:0] ctrl_new  = wb_merge(ctrl_word, req.dat, req.sel);
   wire [31:0] count_new = wb_merge(32'(count_r), req.dat, req.sel);
   wire [31:0] per_new   = wb_merge(32'(period_r), req.dat, req.sel);
   wire [31:0] mask_new  = wb_merge(32'(mask_r), req.dat, req.sel);
   wire [31:0] icfg_word = {28'h0000000, prio_r, irq_en_r};
   wire [31:0] icfg_new  = wb_merge(icfg_word, req.dat, req.sel);

   // unmapped addresses read as zero and still acknowledge
   always_comb begin
      if (hit_ctrl) begin
         rd_data = ctrl_word;
      end else if (hit_count) begin
         rd_data = 32'(count_r);
      end else if (hit_per) begin
         rd_data = 32'(period_r);
      end else if (hit_stat) begin
         rd_data = 32'(status_r);
      end else if (hit_mask) begin
         rd_data = 32'(mask_r);
      end else if (hit_icfg) begin
         rd_data = icfg_word;
      end else begin
         rd_data = 32'h00000000;
      end
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (ctrl_wr) begin
         ctrl_nxt.run       = ctrl_new[`GPT_CTRL_RUN];
         ctrl_nxt.stop_idle = ctrl_new[`GPT_CTRL_SIDL];
         ctrl_nxt.gate_en   = ctrl_new[`GPT_CTRL_GATE];
         ctrl_nxt.prescale  = ctrl_new[`GPT_CTRL_PS_HI:`GPT_CTRL_PS_LO];
         ctrl_nxt.ext_sync  = ctrl_new[`GPT_CTRL_SYNC];
         ctrl_nxt.src_ext   = ctrl_new[`GPT_CTRL_SRC];
      end
   end

   always_comb begin
      case (bus_r)
         gpt_pkg::GPT_BUS_IDLE: bus_nxt = take_w ? gpt_pkg::GPT_BUS_ACK : gpt_pkg::GPT_BUS_IDLE;
         gpt_pkg::GPT_BUS_ACK:  bus_nxt = gpt_pkg::GPT_BUS_IDLE;
         default:               bus_nxt = gpt_pkg::GPT_BUS_IDLE;
      endcase
   end

   // external clock and gate inputs
   logic ext_rise;
   logic gate_level;
   logic gate_fall;

   gpt_edge_sync u_ext_sync (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .sig_i    (ext_clk_i),
      .bypass_i (~ctrl_r.ext_sync),
      .level_o  (),
      .rise_o   (ext_rise),
      .fall_o   ()
   );

   gpt_edge_sync u_gate_sync (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .sig_i    (gate_i),
      .bypass_i (1'b0),
      .level_o  (gate_level),
      .rise_o   (),
      .fall_o   (gate_fall)
   );

   // count source selection and halting
   wire gate_mode  = ~ctrl_r.src_ext & ctrl_r.gate_en;
   wire raw_tick   = ctrl_r.src_ext ? ext_rise : (gate_mode ? gate_level : 1'b1);
   // in sleep the core clock domain is stopped, so only the raw external path survives
   wire sleep_halt = sleep_i & ~(ctrl_r.src_ext & ~ctrl_r.ext_sync);
   wire idle_halt  = idle_i & ctrl_r.stop_idle;
   wire halted     = ~ctrl_r.run | idle_halt | sleep_halt;
   wire pre_tick;

   gpt_prescaler #(
      .DIV_W (`GPT_DIV_W)
   ) u_prescaler (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (halted | ctrl_wr),
      .ratio_i (ps_ratio(ctrl_r.prescale)),
      .tick_i  (raw_tick & ~halted),
      .tick_o  (pre_tick)
   );

   wire at_period  = (count_r == period_r);
   wire match_evt  = pre_tick & at_period;
   wire gate_evt   = ctrl_r.run & gate_mode & gate_fall;

   // named so the load check can sample it a cycle later
   wire [CNT_W-1:0] count_load = count_new[CNT_W-1:0];

   // software load of the count wins over a coincident increment
   always_comb begin
      count_nxt = count_r;
      if (count_wr) begin
         count_nxt = count_load;
      end else if (pre_tick) begin
         count_nxt = at_period ? '0 : count_r + CNT_W'(1);
      end
   end

   // a flag set in the cycle of its read-clear survives
   wire [`GPT_IRQ_W-1:0] stat_set = {gate_evt, match_evt};
   wire [`GPT_IRQ_W-1:0] stat_clr = (rd_w & hit_stat) ? '1 : '0;
   assign status_nxt = (status_r & ~stat_clr) | stat_set;
   wire irq_nxt = irq_en_r & |(status_r & mask_r);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r   <= `GPT_CTRL_RST;
         count_r  <= '0;
         period_r <= '1;
         status_r <= '0;
         mask_r   <= `GPT_MASK_RST;
         irq_en_r <= 1'b0;
         prio_r   <= `GPT_PRIO_RST;
         bus_r    <= gpt_pkg::GPT_BUS_IDLE;
      end else begin
         ctrl_r   <= ctrl_nxt;
         count_r  <= count_nxt;
         status_r <= status_nxt;
         bus_r    <= bus_nxt;
         if (wr_w && hit_per) begin
            period_r <= per_new[CNT_W-1:0];
         end
         if (wr_w && hit_mask) begin
            mask_r <= mask_new[`GPT_IRQ_W-1:0];
         end
         if (wr_w && hit_icfg) begin
            irq_en_r <= icfg_new[`GPT_IRQCFG_EN];
            prio_r   <= icfg_new[`GPT_IRQCFG_PRIO_LO +: `GPT_PRIO_W];
         end
      end
   end

   // output flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o          <= 32'h00000000;
         ack_o          <= 1'b0;
         irq_o          <= 1'b0;
         irq_priority_o <= `GPT_PRIO_RST;
      end else begin
         dat_o          <= rd_w ? rd_data : 32'h00000000;
         ack_o          <= take_w;
         irq_o          <= irq_nxt;
         irq_priority_o <= prio_r;
      end
   end

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_ACK_ONE_CYCLE: assert property (ack_o |=> !ack_o)
      else $error("ack stood longer than one cycle");

   AST_ACK_LATENCY: assert property (cyc_i && stb_i && !ack_o && bus_r == gpt_pkg::GPT_BUS_IDLE
                                     |=> ack_o)
      else $error("request not acknowledged in one cycle");

   AST_RUN_STARTS: assert property (ctrl_wr && ctrl_new[`GPT_CTRL_RUN] && !ctrl_r.run
                                    |=> ctrl_r.run)
      else $error("run bit write did not start the timer");

   AST_STOPPED_HOLDS: assert property (halted && !count_wr |=> count_r == $past(count_r))
      else $error("count moved while stopped");

   AST_INCREMENT: assert property (pre_tick && !at_period && !count_wr
                                   |=> count_r == $past(count_r) + CNT_W'(1))
      else $error("count did not increment on tick");

   AST_WRAP_ZERO: assert property (pre_tick && at_period && !count_wr |=> count_r == '0)
      else $error("count did not return to zero after match");

   AST_MATCH_FLAG: assert property (pre_tick && at_period
                                    |=> status_r[`GPT_IRQ_MATCH])
      else $error("period match did not set its flag");

   AST_GATE_FLAG: assert property (ctrl_r.run && gate_mode && gate_fall
                                   |=> status_r[`GPT_IRQ_GATE])
      else $error("gate falling edge did not set its flag");

   AST_GATE_IGNORED: assert property (ctrl_r.src_ext && !status_r[`GPT_IRQ_GATE]
                                      |=> !status_r[`GPT_IRQ_GATE])
      else $error("gate flag raised with external source");

   AST_IDLE_STOP: assert property (idle_i && ctrl_r.stop_idle |-> !pre_tick)
      else $error("timer ticked in idle with stop-in-idle set");

   AST_IRQ_GATED: assert property (!irq_en_r ##1 !irq_en_r |-> !irq_o)
      else $error("interrupt raised while disabled");

   AST_IRQ_FOLLOWS: assert property (irq_en_r && |(status_r & mask_r) |=> irq_o)
      else $error("pending unmasked flag did not raise interrupt");

   AST_PRESCALE_SPACING: assert property (pre_tick && ctrl_r.prescale != 2'b00
                                          && !$past(ctrl_wr) |-> !$past(pre_tick))
      else $error("divided tick came on consecutive cycles");

   AST_PRESCALE_NONE: assert property (ctrl_r.prescale == 2'b00 && !halted
                                       && !ctrl_r.src_ext && !gate_mode |-> pre_tick)
      else $error("undivided internal clock missed a cycle");

   // register-path and count-source checks, kept apart from the decode they guard
   AST_IDLE_DATA_ZERO: assert property (!ack_o |-> dat_o == 32'h00000000)
      else $error("read data not zero outside the ack cycle");

   AST_STATUS_CLEAR: assert property (rd_w && hit_stat && !(|stat_set) |=> status_r == '0)
      else $error("status read did not clear the flags");

   AST_PRIO_COPY: assert property (1'b1 |=> irq_priority_o == $past(prio_r))
      else $error("priority output does not follow its field");

   AST_GATE_COUNT: assert property (gate_mode && !gate_level |-> !pre_tick)
      else $error("gated timer counted with the gate closed");

   AST_EXT_EDGE: assert property (ctrl_r.src_ext && !ext_rise |-> !pre_tick)
      else $error("external count without an external edge");

   AST_SLEEP_HALT: assert property (sleep_i
                                    && !(ctrl_r.src_ext && !ctrl_r.ext_sync) |-> !pre_tick)
      else $error("clocked path counted in sleep");

   AST_COUNT_LOAD: assert property (count_wr |=> count_r == $past(count_load))
      else $error("software load of the count was lost");

   AST_CTRL_READ: assert property (rd_w && hit_ctrl |=> ctrl_r == $past(ctrl_r))
      else $error("control read changed the control bits");
endmodule

// File: sim/gpt_ext_src.sv
// external count clock and gate source facing the timer
`timescale 1ns/10ps
module gpt_ext_src #(
   parameter int HALF = 3
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // requests from the bench
   input  wire logic clk_en_i,
   input  wire logic gate_req_i,
   // pins into the timer
   output logic      ext_clk_o,
   output logic      gate_o
);
   int unsigned ph_r;
   // clock stands low between frames so no stray edge gets counted
   always_ff @(posedge clk_i) begin
      if (rst_i || !clk_en_i) begin
         ph_r      <= 0;
         ext_clk_o <= 1'b0;
      end else if (ph_r == HALF - 1) begin
         ph_r      <= 0;
         ext_clk_o <= !ext_clk_o;
      end else begin
         ph_r <= ph_r + 1;
      end
   end
   always_ff @(posedge clk_i) begin
      gate_o <= rst_i ? 1'b0 : gate_req_i;
   end
endmodule

// File: sim/tb_top.sv
// self-checking bench for the gated prescaled period timer
`timescale 1ns/10ps
`include "gpt_cfg.svh"
module tb_top;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] per;
      logic        ext;
      logic [31:0] gap;
   } gpt_row_t;
   logic        clk_i    = 1'b0;
   logic        rst_i    = 1'b1;
   logic        cyc_i    = 1'b0;
   logic        stb_i    = 1'b0;
   logic        we_i     = 1'b0;
   logic [7:0]  adr_i    = 8'h00;
   logic [31:0] dat_i    = 32'h0;
   logic        idle_i   = 1'b0;
   logic        sleep_i  = 1'b0;
   logic        ext_en   = 1'b0;
   logic        gate_req = 1'b0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        irq_o;
   logic [2:0]  irq_priority_o;
   logic        ext_clk;
   logic        gate;
   logic [31:0] d;
   logic [31:0] a;
   int          err_count = 0;
   int          checked   = 0;
   int          cyc_n     = 0;
   int          t1;
   int          t2;
   // ext clock period is six system clocks
   gpt_row_t rows [8] = '{
      '{16'h8000, 16'd9, 1'b0, 32'd10},  '{16'h8010, 16'd3, 1'b0, 32'd32},
      '{16'h8020, 16'd1, 1'b0, 32'd128}, '{16'h8030, 16'd1, 1'b0, 32'd512},
      '{16'h8006, 16'd4, 1'b1, 32'd30},  '{16'h8002, 16'd4, 1'b1, 32'd30},
      '{16'h8046, 16'd4, 1'b1, 32'd30},  '{16'h8016, 16'd1, 1'b1, 32'd96}};

   always #10 clk_i = !clk_i;
   always @(posedge clk_i) cyc_n <= cyc_n + 1;

   gpt_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .idle_i(idle_i), .sleep_i(sleep_i), .ext_clk_i(ext_clk),
      .gate_i(gate), .irq_o(irq_o), .irq_priority_o(irq_priority_o));
   gpt_ext_src #(.HALF(3)) SRC (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(ext_en),
      .gate_req_i(gate_req), .ext_clk_o(ext_clk), .gate_o(gate));

   task automatic wrap_up();
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // request held until the edge that samples ack
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= ad;
      dat_i <= wd;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) begin
            rd = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            return;
         end
      end
      err_count++;
      wrap_up();
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      logic [31:0] x;
      bus(1'b1, ad, wd, x);
   endtask

   task automatic wait_rise(output int t);
      logic prev;
      prev = 1'b1;
      for (int n = 0; n < 3000; n++) begin
         @(posedge clk_i);
         if (irq_o === 1'b1 && prev === 1'b0) begin
            t = cyc_n;
            return;
         end
         prev = irq_o;
      end
      err_count++;
      wrap_up();
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, `GPT_OFF_CTRL, 32'h0, d);
      chk(d, 32'h0);
      bus(1'b0, `GPT_OFF_COUNT, 32'h0, d);
      chk(d, 32'h0);
      bus(1'b0, `GPT_OFF_PERIOD, 32'h0, d);
      chk(d, 32'h0000FFFF);
      bus(1'b0, `GPT_OFF_STATUS, 32'h0, d);
      chk(d, 32'h0);
      bus(1'b0, `GPT_OFF_MASK, 32'h0, d);
      chk(d, 32'h3);
      bus(1'b0, `GPT_OFF_IRQCFG, 32'h0, d);
      chk(d, 32'h0);
      bus(1'b0, 8'h18, 32'h0, d);
      chk(d, 32'h0);
      chk(irq_o, 1'b0);
      $display("reset test done");
      wr(`GPT_OFF_IRQCFG, 32'h0000000B);
      for (int i = 0; i < 8; i++) begin
         wr(`GPT_OFF_CTRL, 32'h0);
         wr(`GPT_OFF_COUNT, 32'h0);
         wr(`GPT_OFF_PERIOD, rows[i].per);
         bus(1'b0, `GPT_OFF_STATUS, 32'h0, d);
         ext_en <= rows[i].ext;
         wr(`GPT_OFF_CTRL, rows[i].ctrl);
         wait_rise(t1);
         bus(1'b0, `GPT_OFF_STATUS, 32'h0, d);
         chk(d, 32'h1);
         wait_rise(t2);
         chk(32'(t2 - t1), rows[i].gap);
         chk(irq_priority_o, 3'h5);
         $display("row %0d done", i);
      end
      ext_en <= 1'b0;
      // masked or disabled events must not reach the cpu
      wr(`GPT_OFF_CTRL, 32'h0);
      wr(`GPT_OFF_PERIOD, 32'h2);
      wr(`GPT_OFF_MASK, 32'h2);
      bus(1'b0, `GPT_OFF_STATUS, 32'h0, d);
      wr(`GPT_OFF_CTRL, 32'h8000);
      repeat (20) @(posedge clk_i);
      chk(irq_o, 1'b0);
      bus(1'b0, `GPT_OFF_STATUS, 32'h0, d);
      chk(d, 32'h1);
      wr(`GPT_OFF_MASK, 32'h3);
      // flag is already pending, so the line rises one edge after the mask register is written
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b1);
      wr(`GPT_OFF_IRQCFG, 32'h0000000A);
      repeat (3) @(posedge clk_i);
      chk(irq_o, 1'b0);
      $display("irq test done");
      wr(`GPT_OFF_CTRL, 32'h0);
      wr(`GPT_OFF_COUNT, 32'h5);
      wr(`GPT_OFF_PERIOD, 32'hFFFF);
      repeat (20) @(posedge clk_i);
      bus(1'b0, `GPT_OFF_COUNT, 32'h0, d);
      chk(d, 32'h5);
      idle_i <= 1'b1;
      wr(`GPT_OFF_CTRL, 32'hA000);
      repeat (20) @(posedge clk_i);
      bus(1'b0, `GPT_OFF_COUNT, 32'h0, d);
      chk(d, 32'h5);
      wr(`GPT_OFF_CTRL, 32'h8000);
      bus(1'b0, `GPT_OFF_COUNT, 32'h0, a);
      bus(1'b0, `GPT_OFF_COUNT, 32'h0, d);
      chk(32'(d !== a), 32'h1);
      idle_i  <= 1'b0;
      sleep_i <= 1'b1;
      wr(`GPT_OFF_CTRL, 32'h8000);
      bus(1'b0, `GPT_OFF_COUNT, 32'h0, a);
      repeat (10) @(posedge clk_i);
      bus(1'b0, `GPT_OFF_COUNT, 32'h0, d);
      chk(d, a);
      ext_en <= 1'b1;
      wr(`GPT_OFF_CTRL, 32'h8002);
      bus(1'b0, `GPT_OFF_COUNT, 32'h0, a);
      repeat (30) @(posedge clk_i);
      bus(1'b0, `GPT_OFF_COUNT, 32'h0, d);
      chk(32'(d !== a), 32'h1);
      sleep_i <= 1'b0;
      ext_en  <= 1'b0;
      $display("halt test done");
      wr(`GPT_OFF_CTRL, 32'h0);
      wr(`GPT_OFF_COUNT, 32'h0);
      bus(1'b0, `GPT_OFF_STATUS, 32'h0, d);
      wr(`GPT_OFF_CTRL, 32'h8040);
      repeat (5) @(posedge clk_i);
      gate_req <= 1'b1;
      repeat (20) @(posedge clk_i);
      gate_req <= 1'b0;
      repeat (10) @(posedge clk_i);
      bus(1'b0, `GPT_OFF_COUNT, 32'h0, d);
      chk(d, 32'd20);
      bus(1'b0, `GPT_OFF_STATUS, 32'h0, d);
      chk(d, 32'h2);
      bus(1'b0, `GPT_OFF_STATUS, 32'h0, d);
      chk(d, 32'h0);
      $display("gate test done");
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(irq_priority_o, 3'h0);
      chk(irq_o, 1'b0);
      bus(1'b0, `GPT_OFF_CTRL, 32'h0, d);
      chk(d, 32'h0);
      bus(1'b0, `GPT_OFF_PERIOD, 32'h0, d);
      chk(d, 32'h0000FFFF);
      bus(1'b0, `GPT_OFF_IRQCFG, 32'h0, d);
      chk(d, 32'h0);
      $display("mid-run reset test done");
      wrap_up();
   end
endmodule
